//--- verilog/imf_framer.sv
/*
  IMU field framer: accumulates compensated accelerometer samples, encodes
  the measurement fields MSB first into a byte stream and runs the mode
  control (init, normal, service, utility) behind an APB register slave.
  Assumes all inputs synchronous to pclk and a byte sink that may stall.
*/
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps

module imf_framer #(
  parameter int SAMPLE_CYC = imf_pkg::SAMPLE_CYC,
  parameter int ADDR_W     = 8
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [ADDR_W-1:0]    paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire imf_pkg::imf_sensor_t sens,
  input  wire logic                 ext_reset,
  output logic      [7:0]           tx_data,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output logic                      info_report,
  output logic                      mode_ack,
  output imf_pkg::imf_mode_t        mode
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    logic [7:0] base;
    base = (n < 4'ha) ? imf_pkg::ASCII_0 : imf_pkg::ASCII_A10;
    return base + {4'h0, n};
  endfunction

  // Bitwise CRC-8, MSB first
  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int b = 0; b < 8; b++) begin
      r = r[7] ? ((r << 1) ^ imf_pkg::CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  imf_pkg::imf_state_t st_ff;
  imf_pkg::imf_state_t nxt_st;

  logic                 us_tick;
  logic                 smp_tick;
  logic                 tx_tick;
  logic                 fire;
  logic                 wr_en;
  logic                 cmd_wr;
  logic                 mapped;
  logic                 pps_edge;
  logic [7:0]           n_last;
  logic [7:0]           tx_byte;
  logic [47:0]          tail;
  logic [5:0]           len_nib;
  logic [2:0][23:0]     adj;
  logic [2:0][23:0]     field;
  logic signed [39:0]   prod    [3];
  logic [39:0]          inc_n   [3];
  logic [39:0]          integ_n [3];
  logic [31:0]          avg_n   [3];
  logic signed [31:0]   avg_sh  [3];
  logic [23:0]          pps_f;
  logic [imf_pkg::FRAME_W-1:0] frame;

  // ----------------------------------------------------------------------
  // Ticks and bus decode
  // ----------------------------------------------------------------------
  // Divider enables: 1 us and the 2000/s internal sample
  assign us_tick  = st_ff.us_div == 6'(imf_pkg::US_CYC - 1);
  assign smp_tick = st_ff.div == 16'(SAMPLE_CYC - 1);
  assign n_last   = (8'h01 << st_ff.cfg.rate_shift) - 8'h01;
  // At or past the end: a smaller rate written mid-window must not leave
  // the window counter running on to its wrap before the next frame
  assign tx_tick  = smp_tick && (st_ff.ncnt >= n_last);
  assign wr_en    = psel && penable && pwrite;
  assign cmd_wr   = wr_en && (paddr == imf_pkg::OFF_CMD);
  assign mapped   = paddr inside {imf_pkg::OFF_CTRL, imf_pkg::OFF_CMD,
                                  imf_pkg::OFF_STATUS, imf_pkg::OFF_BIAS_X,
                                  imf_pkg::OFF_BIAS_Y, imf_pkg::OFF_BIAS_Z};
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  // Read mux; unmapped and command addresses read as zero
  always_comb begin
    imf_pkg::imf_status_t s;
    s = '{shot: st_ff.shot, busy: st_ff.nib != 6'h00, mode: st_ff.mode};
    case (paddr)
      imf_pkg::OFF_CTRL:   prdata = {{(32-imf_pkg::CFG_W){1'b0}}, st_ff.cfg};
      imf_pkg::OFF_STATUS: prdata = {{(32-$bits(s)){1'b0}}, s};
      imf_pkg::OFF_BIAS_X: prdata = {8'h00, st_ff.bias[0]};
      imf_pkg::OFF_BIAS_Y: prdata = {8'h00, st_ff.bias[1]};
      imf_pkg::OFF_BIAS_Z: prdata = {8'h00, st_ff.bias[2]};
      default:             prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Per-axis field arithmetic
  // ----------------------------------------------------------------------
  // Trim is in g like the compensated sample, so it is added before any
  // velocity scaling; that keeps it in g for every output unit.
  for (genvar i = 0; i < 3; i++) begin : g_axis
    assign adj[i]     = sens.accel[i] + st_ff.bias[i];
    assign prod[i]    = $signed(adj[i]) * $signed({1'b0, imf_pkg::VEL_K});
    assign inc_n[i]   = st_ff.inc[i] + prod[i];
    assign integ_n[i] = st_ff.integ[i] + prod[i];
    assign avg_n[i]   = st_ff.avg[i] + 32'($signed(adj[i]));
    assign avg_sh[i]  = $signed(avg_n[i]) >>> st_ff.cfg.rate_shift;
    // Top 24 bits of the Q16 sums: 2^22 per m/s, the wrap is silent
    assign field[i] =
      (st_ff.cfg.acc_unit == imf_pkg::ACC_INCR)  ? inc_n[i][39:16] :
      (st_ff.cfg.acc_unit == imf_pkg::ACC_AVG)   ? avg_sh[i][23:0] :
      (st_ff.cfg.acc_unit == imf_pkg::ACC_INTEG) ? integ_n[i][39:16] :
                                                   adj[i];
  end

  // ----------------------------------------------------------------------
  // Frame assembly
  // ----------------------------------------------------------------------
  assign pps_f = (st_ff.cfg.pps_unit == imf_pkg::PPS_FILT) ?
                 st_ff.filt : st_ff.pps_us;
  // Tail fields packed MSB first, left aligned
  always_comb begin
    case ({st_ff.cfg.temp_en, st_ff.cfg.cnt16})
      2'b11:   tail = {sens.temp, st_ff.cnt, st_ff.lat};
      2'b10:   tail = {sens.temp, st_ff.cnt[7:0], st_ff.lat, 8'h00};
      2'b01:   tail = {st_ff.cnt, st_ff.lat, 16'h0000};
      default: tail = {st_ff.cnt[7:0], st_ff.lat, 24'h00_0000};
    endcase
  end
  assign len_nib = imf_pkg::HEAD_NIB + 6'h04
                 + (st_ff.cfg.temp_en ? 6'h04 : 6'h00)
                 + (st_ff.cfg.cnt16 ? 6'h04 : 6'h02);
  assign frame = {field[0], field[1], field[2], pps_f, tail};

  // Byte stream; ASCII mode spends one character per nibble
  assign tx_byte  = st_ff.sh[143:136];
  assign tx_valid = st_ff.nib != 6'h00;
  assign fire     = tx_valid && tx_ready;
  assign tx_data  = st_ff.ascii ? hex_char(st_ff.sh[143:140]) : tx_byte;
  assign pps_edge = (st_ff.cfg.pps_unit == imf_pkg::PPS_T1) ?
                    (sens.pps && !st_ff.pps_prev) :
                    (!sens.pps && st_ff.pps_prev);

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.info = 1'b0;
    nxt_st.ack  = 1'b0;
    // Dividers
    nxt_st.us_div = us_tick ? 6'h00 : st_ff.us_div + 6'h01;
    nxt_st.div    = smp_tick ? 16'h0000 : st_ff.div + 16'h0001;
    // Age of the oldest sample in the window, saturating
    if (tx_tick) begin
      nxt_st.lat = 16'h0000;
    end else if (us_tick && st_ff.lat != imf_pkg::LAT_MAX) begin
      nxt_st.lat = st_ff.lat + 16'h0001;
    end
    // Microseconds since the chosen pps edge was detected, saturating
    nxt_st.pps_prev = sens.pps;
    if (pps_edge) begin
      nxt_st.pps_us = 24'h00_0000;
    end else if (us_tick && st_ff.pps_us != imf_pkg::PPS_US_MAX) begin
      nxt_st.pps_us = st_ff.pps_us + 24'h00_0001;
    end
    // Accumulation keeps running in every mode
    if (smp_tick) begin
      nxt_st.filt = 24'($signed({1'b0, st_ff.filt})
                  + (($signed(sens.pps ? imf_pkg::PPS_ONE : 25'h0)
                  - $signed({1'b0, st_ff.filt})) >>> imf_pkg::FILT_SHIFT));
      for (int i = 0; i < 3; i++) begin
        nxt_st.integ[i] = integ_n[i];
        nxt_st.inc[i]   = tx_tick ? 40'h0 : inc_n[i];
        nxt_st.avg[i]   = tx_tick ? 32'h0 : avg_n[i];
      end
      nxt_st.ncnt = tx_tick ? 8'h00 : st_ff.ncnt + 8'h01;
      if (tx_tick) begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
    end
    // Shift out; a CRC byte follows utility-mode responses
    if (fire) begin
      if (st_ff.ascii) begin
        nxt_st.sh  = st_ff.sh << 4;
        nxt_st.nib = st_ff.nib - 6'h01;
      end else begin
        nxt_st.sh  = st_ff.sh << 8;
        nxt_st.nib = st_ff.nib - 6'h02;
        nxt_st.crc = crc8(st_ff.crc, tx_byte);
        if (st_ff.nib == 6'h02 && st_ff.crc_on) begin
          nxt_st.sh     = {crc8(st_ff.crc, tx_byte), 136'h0};
          nxt_st.nib    = 6'h02;
          nxt_st.crc_on = 1'b0;
        end
      end
    end
    // Frames only in normal mode; elsewhere only on request
    if (tx_tick && !tx_valid &&
        (st_ff.mode == imf_pkg::MODE_NORMAL || st_ff.shot)) begin
      nxt_st.sh     = frame;
      // One character per nibble in ASCII, two nibbles per binary byte,
      // so one nibble count serves both
      nxt_st.nib    = len_nib;
      nxt_st.ascii  = st_ff.mode == imf_pkg::MODE_SERVICE;
      nxt_st.crc_on = st_ff.mode == imf_pkg::MODE_UTILITY;
      nxt_st.crc    = imf_pkg::CRC_INIT;
      nxt_st.shot   = 1'b0;
    end
    // Init leaves for normal at the next internal sample
    if (st_ff.mode == imf_pkg::MODE_INIT && smp_tick) begin
      nxt_st.mode = imf_pkg::MODE_NORMAL;
    end
    // Register writes
    if (wr_en && paddr == imf_pkg::OFF_CTRL) begin
      nxt_st.cfg = pwdata[imf_pkg::CFG_W-1:0];
    end
    if (wr_en && paddr == imf_pkg::OFF_BIAS_X) nxt_st.bias[0] = pwdata[23:0];
    if (wr_en && paddr == imf_pkg::OFF_BIAS_Y) nxt_st.bias[1] = pwdata[23:0];
    if (wr_en && paddr == imf_pkg::OFF_BIAS_Z) nxt_st.bias[2] = pwdata[23:0];
    if (cmd_wr) begin
      if (pwdata[imf_pkg::CMD_SAVE]) nxt_st.saved = st_ff.cfg;
      case (st_ff.mode)
        imf_pkg::MODE_NORMAL: begin
          if (pwdata[imf_pkg::CMD_SVC]) begin
            nxt_st.mode = imf_pkg::MODE_SERVICE;
            nxt_st.info = 1'b1;
          end else if (pwdata[imf_pkg::CMD_UTIL]) begin
            nxt_st.mode = imf_pkg::MODE_UTILITY;
            nxt_st.ack  = 1'b1;
          end
        end
        imf_pkg::MODE_SERVICE, imf_pkg::MODE_UTILITY: begin
          if (pwdata[imf_pkg::CMD_EXIT_NORM]) begin
            nxt_st.mode = imf_pkg::MODE_NORMAL;
          end else if (pwdata[imf_pkg::CMD_EXIT_INIT] &&
                       st_ff.mode == imf_pkg::MODE_SERVICE) begin
            nxt_st.mode = imf_pkg::MODE_INIT;
            nxt_st.cfg  = st_ff.saved;
          end else if (pwdata[imf_pkg::CMD_SHOT]) begin
            nxt_st.shot = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // External reset wins over every field it loads; a same-cycle command still pulses info or ack
    if (ext_reset) begin
      nxt_st.mode  = imf_pkg::MODE_INIT;
      nxt_st.cfg   = st_ff.saved;
      nxt_st.integ = '0;
      nxt_st.inc   = '0;
      nxt_st.avg   = '0;
      nxt_st.ncnt  = 8'h00;
      nxt_st.nib   = 6'h00;
      nxt_st.shot  = 1'b0;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff       <= '0;
      st_ff.cfg   <= imf_pkg::CFG_RST;
      st_ff.saved <= imf_pkg::CFG_RST;
      st_ff.mode  <= imf_pkg::MODE_INIT;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign info_report = st_ff.info;
  assign mode_ack    = st_ff.ack;
  assign mode        = st_ff.mode;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        bus_idle;
  logic [23:0] adj0;
  assign bus_idle = !(psel && penable);
  assign adj0     = adj[0];

  svc_ascii_a: assert property (
    (st_ff.mode == imf_pkg::MODE_SERVICE && tx_valid && !ext_reset &&
     bus_idle) |=> !tx_valid || st_ff.ascii ||
    st_ff.mode != imf_pkg::MODE_SERVICE)
    else $error("service mode streamed binary bytes");
  svc_info_a: assert property (
    (cmd_wr && pwdata[0] && st_ff.mode == imf_pkg::MODE_NORMAL &&
     !ext_reset) |=> info_report ##1 !info_report)
    else $error("service entry gave no one-cycle report pulse");
  util_ack_a: assert property (
    (cmd_wr && pwdata[1:0] == 2'b10 && st_ff.mode == imf_pkg::MODE_NORMAL &&
     !ext_reset) |=> mode_ack && st_ff.mode == imf_pkg::MODE_UTILITY)
    else $error("utility entry not acknowledged");
  no_frame_util_a: assert property (
    (st_ff.mode inside {imf_pkg::MODE_SERVICE, imf_pkg::MODE_UTILITY} &&
     !st_ff.shot && !tx_valid) |=> !tx_valid)
    else $error("frame started without single-shot request");
  crc_tail_a: assert property (
    (fire && st_ff.crc_on && st_ff.nib == 6'h02 && !ext_reset) |=>
    tx_valid && tx_data == $past(crc8(st_ff.crc, tx_byte)))
    else $error("utility frame not followed by its CRC byte");
  ext_init_a: assert property (
    ext_reset |=> st_ff.mode == imf_pkg::MODE_INIT &&
    st_ff.cfg == $past(st_ff.saved) && st_ff.integ == '0)
    else $error("external reset did not return to init");
  util_exit_a: assert property (
    (cmd_wr && pwdata[2] && st_ff.mode == imf_pkg::MODE_UTILITY &&
     !ext_reset) |=> st_ff.mode == imf_pkg::MODE_NORMAL)
    else $error("utility exit did not resume normal mode");
  integ_hold_a: assert property (
    (!smp_tick && !ext_reset) |=> $stable(st_ff.integ))
    else $error("integrated velocity moved between samples");
  bias_sum_a: assert property (
    (tx_tick && !tx_valid && st_ff.mode == imf_pkg::MODE_NORMAL &&
     st_ff.cfg.acc_unit == imf_pkg::ACC_PLAIN && !ext_reset) |=>
    st_ff.sh[143:120] == $past(adj0))
    else $error("first axis field is not sample plus trim");
  win_restart_a: assert property (
    (tx_tick && !ext_reset) |=> st_ff.ncnt == 8'h00 &&
    st_ff.inc == '0 && st_ff.avg == '0)
    else $error("window accumulators not restarted after a frame");
  cnt_step_a: assert property (
    (tx_tick && !ext_reset) |=> st_ff.cnt == $past(st_ff.cnt) + 16'h0001)
    else $error("sample counter did not step once per frame");

  shot_svc_c:   cover property (st_ff.shot && tx_tick && !tx_valid &&
                                st_ff.mode == imf_pkg::MODE_SERVICE);
  crc_util_c:   cover property (fire && st_ff.crc_on && st_ff.nib == 6'h02);
  exit_norm_c:  cover property (cmd_wr && pwdata[2] &&
                                st_ff.mode == imf_pkg::MODE_SERVICE);
  stall_c:      cover property ((tx_valid && !tx_ready) [*3]);

endmodule

//--- verilog/imf_pkg.sv
/*
  Package of the IMU field framer: register map, timing counts, mode and
  unit encodings, carriers and the framer state record.
  Assumes a 40 MHz APB clock and a 2000 samples/s internal sample rate.
*/
package imf_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_NS     = 25;
  localparam int US_NS      = 1000;
  localparam int US_CYC     = US_NS / CLK_NS;
  localparam int SAMPLE_NS  = 500000;              // 2000 samples/s
  localparam int SAMPLE_CYC = SAMPLE_NS / CLK_NS;

  // ----------------------------------------------------------------------
  // Register map (byte addresses) and command bits
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_CMD    = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_BIAS_X = 8'h0c;
  localparam logic [7:0] OFF_BIAS_Y = 8'h10;
  localparam logic [7:0] OFF_BIAS_Z = 8'h14;
  localparam int CMD_SVC       = 0;
  localparam int CMD_UTIL      = 1;
  localparam int CMD_EXIT_NORM = 2;
  localparam int CMD_EXIT_INIT = 3;
  localparam int CMD_SAVE      = 4;
  localparam int CMD_SHOT      = 5;

  // ----------------------------------------------------------------------
  // Arithmetic constants
  // ----------------------------------------------------------------------
  // 9.80665 m/s2 * 2^22 / 2^19 / 2000 in Q16: g-counts to velocity counts
  localparam logic [12:0]  VEL_K      = 13'h0a0b;
  localparam int           VEL_FRAC   = 16;
  localparam int           FILT_SHIFT = 4;
  localparam logic [24:0]  PPS_ONE    = 25'h0400000;   // 1.0 at 2^22
  localparam logic [23:0]  PPS_US_MAX = 24'h7fffff;
  localparam logic [15:0]  LAT_MAX    = 16'hffff;
  localparam logic [7:0]   CRC_POLY   = 8'h07;
  localparam logic [7:0]   CRC_INIT   = 8'h00;
  localparam logic [7:0]   ASCII_0    = 8'h30;
  localparam logic [7:0]   ASCII_A10  = 8'h57;
  localparam logic [5:0]   HEAD_NIB   = 6'h18;         // 3 axes + pps
  localparam int           FRAME_W    = 144;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_INIT = 2'b00, MODE_NORMAL = 2'b01,
    MODE_SERVICE = 2'b10, MODE_UTILITY = 2'b11
  } imf_mode_t;

  typedef enum logic [1:0] {
    ACC_PLAIN = 2'b00, ACC_INCR = 2'b01, ACC_AVG = 2'b10, ACC_INTEG = 2'b11
  } imf_acc_unit_t;

  typedef enum logic [1:0] {
    PPS_T0 = 2'b00, PPS_T1 = 2'b01, PPS_FILT = 2'b10, PPS_RSVD = 2'b11
  } imf_pps_unit_t;

  typedef struct packed {
    logic [2:0]    rate_shift;   // n = 2^rate_shift samples per frame
    logic          cnt16;
    logic          temp_en;
    imf_pps_unit_t pps_unit;
    imf_acc_unit_t acc_unit;
  } imf_cfg_t;
  localparam int       CFG_W   = $bits(imf_cfg_t);
  localparam imf_cfg_t CFG_RST = '{rate_shift: 3'h2, cnt16: 1'b1,
                                   temp_en: 1'b1, pps_unit: PPS_T0,
                                   acc_unit: ACC_PLAIN};

  typedef struct packed {
    logic      shot;
    logic      busy;
    imf_mode_t mode;
  } imf_status_t;

  // Compensated sensor samples, accel in g at 2^19 counts/g
  typedef struct packed {
    logic [2:0][23:0] accel;
    logic [15:0]      temp;
    logic             pps;
  } imf_sensor_t;

  typedef struct packed {
    imf_mode_t        mode;
    imf_cfg_t         cfg;
    imf_cfg_t         saved;
    logic [2:0][23:0] bias;
    logic [15:0]      div;
    logic [5:0]       us_div;
    logic [7:0]       ncnt;
    logic [2:0][39:0] inc;
    logic [2:0][39:0] integ;
    logic [2:0][31:0] avg;
    logic             pps_prev;
    logic [23:0]      pps_us;
    logic [23:0]      filt;
    logic [15:0]      cnt;
    logic [15:0]      lat;
    logic [FRAME_W-1:0] sh;
    logic [5:0]       nib;
    logic             ascii;
    logic             crc_on;
    logic [7:0]       crc;
    logic             shot;
    logic             info;
    logic             ack;
  } imf_state_t;

endpackage

//--- dv/imf_host_sink.sv
/*
  Host-side byte sink for the field framer stream, kept in a queue.
  Assumes the pclk domain; slow makes it stall every other cycle.
*/
`timescale 1ns/1ps
module imf_host_sink (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  output logic            tx_ready,
  input  wire logic       slow
);
  logic [7:0] rx_q [$];
  logic       rdy_ff;
  // ----------------------------------------------------------------
  // Accept
  // ----------------------------------------------------------------
  // Ready toggles when slow, so the framer has to hold each byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdy_ff <= 1'h0;
    end else begin
      rdy_ff <= slow ? ~rdy_ff : 1'h1;
      if (tx_valid && rdy_ff) begin
        rx_q.push_back(tx_data);
      end
    end
  end
  assign tx_ready = rdy_ff;
endmodule

//--- dv/tb_top.sv
/*
  Bench of the field framer: register rows, frame rows per unit, then
  mode changes and external reset by hand.
  Assumes imf_pkg, imf_framer and imf_host_sink are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin n_compared++; if ((got) !== (ex)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_top;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic e;} imf_row_t;
  typedef struct {logic [31:0] c; int n; logic [23:0] x;} imf_fr_t;
  localparam logic [31:0] RST = 32'(imf_pkg::CFG_RST);
  logic                 pclk, presetn, psel, penable, pwrite, e, hit, bz;
  logic                 pready, pslverr, ext_reset, slow;
  logic                 tx_valid, tx_ready, info_report, mode_ack;
  logic [7:0]           paddr, tx_data;
  logic [31:0]          pwdata, prdata, rd;
  logic [23:0]          v0;
  logic [7:0]           f [$];
  imf_pkg::imf_sensor_t sens;
  imf_pkg::imf_mode_t   mode;
  int                   mismatches, n_compared;
  imf_row_t rows [9] = '{
    '{1'h1, imf_pkg::OFF_BIAS_X, 32'hff000100, 1'h0},
    '{1'h0, imf_pkg::OFF_BIAS_X, 32'h00000100, 1'h0},
    '{1'h1, imf_pkg::OFF_BIAS_Y, 32'h00fffff0, 1'h0},
    '{1'h0, imf_pkg::OFF_BIAS_Y, 32'h00fffff0, 1'h0},
    '{1'h1, imf_pkg::OFF_BIAS_Z, 32'h0, 1'h0},
    '{1'h0, imf_pkg::OFF_CTRL, RST, 1'h0},
    '{1'h0, imf_pkg::OFF_CMD, 32'h0, 1'h0},
    '{1'h1, 8'h18, 32'h1, 1'h1},
    '{1'h0, 8'h18, 32'h0, 1'h1}};
  // X sample plus X trim is 0x10000 g-counts in every row
  imf_fr_t frs [4] = '{'{RST, 18, 24'h010000}, '{RST | 32'h1, 18, 24'h00282c},
    '{RST | 32'h2, 18, 24'h010000}, '{32'h80, 15, 24'h010000}};
  imf_framer #(.SAMPLE_CYC(40)) u_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sens(sens), .ext_reset(ext_reset), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .info_report(info_report),
    .mode_ack(mode_ack), .mode(mode));
  imf_host_sink u_host (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .slow(slow));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r,
                     output logic er);
    int k;
    k = 0;
    // Idle edge first, so back-to-back calls never drive psel twice at once
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'h1 && k < 50);
    if (pready !== 1'h1) mismatches++;
    r = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic cmd(input int n);
    apb(1'h1, imf_pkg::OFF_CMD, 32'h1 << n, rd, e);
  endtask
  // Bounded wait while the stream busy level equals lvl
  task automatic wait_tx(input logic lvl);
    int k;
    k = 0;
    while (tx_valid === lvl && k < 2000) begin
      @(posedge pclk);
      k++;
    end
    if (tx_valid === lvl) mismatches++;
  endtask
  // One whole frame, starting from an idle stream
  task automatic grab();
    wait_tx(1'h1);
    u_host.rx_q.delete();
    wait_tx(1'h0);
    wait_tx(1'h1);
    f = u_host.rx_q;
  endtask
  // Pulse soon after a mode command, then any stream traffic at all
  task automatic watch(input logic util);
    hit = 1'h0;
    bz = 1'h0;
    for (int i = 0; i < 400; i++) begin
      @(posedge pclk);
      if (i < 4 && (util ? mode_ack : info_report) === 1'h1) hit = 1'h1;
      if (tx_valid === 1'h1) bz = 1'h1;
    end
  endtask
  // Reference CRC-8 over the first n bytes of f, MSB first
  function automatic logic [7:0] crc_of(input int n);
    logic [7:0] c;
    c = imf_pkg::CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ f[i];
      for (int b = 0; b < 8; b++) begin
        c = c[7] ? ((c << 1) ^ imf_pkg::CRC_POLY) : (c << 1);
      end
    end
    return c;
  endfunction
  task automatic results();
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    #500000;
    mismatches++;
    results();
  end
  initial begin
    {presetn, psel, penable, pwrite, ext_reset, paddr, pwdata} = '0;
    slow = 1'h1;
    sens = '{accel: '{24'hffff00, 24'h000020, 24'h00ff00},
             temp: 16'h1980, pps: 1'h1};
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d, rd, e);
      `CHK("pslverr", rows[i].e, e)
      if (!rows[i].w) `CHK("prdata", rows[i].d, rd)
    end
    // Trim in g shows in every unit, counts per frame from rate
    foreach (frs[i]) begin
      apb(1'h1, imf_pkg::OFF_CTRL, frs[i].c, rd, e);
      grab();
      grab();
      `CHK("frame_len", frs[i].n, f.size())
      `CHK("x_field", frs[i].x, {f[0], f[1], f[2]})
    end
    apb(1'h1, imf_pkg::OFF_CTRL, RST | 32'h3, rd, e);
    grab();
    v0 = {f[0], f[1], f[2]};
    grab();
    `CHK("integ", v0 + 24'h00282c, {f[0], f[1], f[2]})
    `CHK("temp", 16'h1980, {f[12], f[13]})
    // Rising pps edge just after a frame: next frame sees at most 4 us
    apb(1'h1, imf_pkg::OFF_CTRL, RST | 32'h4, rd, e);
    grab();
    sens.pps <= 1'h0;
    @(posedge pclk);
    sens.pps <= 1'h1;
    grab();
    `CHK("pps_t1", 1'h1, ({f[9], f[10], f[11]} <= 24'h000004))
    apb(1'h1, imf_pkg::OFF_CTRL, RST | 32'h8, rd, e);
    grab();
    grab();
    `CHK("filt", 1'h1, ({f[9], f[10], f[11]} <= 24'h400000))
    apb(1'h1, imf_pkg::OFF_CTRL, RST, rd, e);
    grab();
    cmd(imf_pkg::CMD_SVC);
    watch(1'h0);
    `CHK("info", 1'h1, hit)
    `CHK("svc_quiet", 1'h0, bz)
    `CHK("svc_mode", imf_pkg::MODE_SERVICE, mode)
    apb(1'h1, imf_pkg::OFF_CTRL, 32'h80, rd, e);
    cmd(imf_pkg::CMD_SHOT);
    grab();
    `CHK("ascii_len", 30, f.size())
    `CHK("ascii_x", 16'h3031, {f[0], f[1]})
    cmd(imf_pkg::CMD_EXIT_NORM);
    grab();
    `CHK("exit_keep", 15, f.size())
    cmd(imf_pkg::CMD_UTIL);
    watch(1'h1);
    `CHK("ack", 1'h1, hit)
    `CHK("util_quiet", 1'h0, bz)
    `CHK("util_mode", imf_pkg::MODE_UTILITY, mode)
    cmd(imf_pkg::CMD_SHOT);
    grab();
    `CHK("crc_len", 16, f.size())
    `CHK("crc_byte", crc_of(15), f[15])
    cmd(imf_pkg::CMD_EXIT_NORM);
    grab();
    `CHK("resume", 15, f.size())
    ext_reset <= 1'h1;
    @(posedge pclk);
    ext_reset <= 1'h0;
    @(posedge pclk);
    `CHK("xr_mode", imf_pkg::MODE_INIT, mode)
    apb(1'h0, imf_pkg::OFF_CTRL, 32'h0, rd, e);
    `CHK("xr_ctrl", RST, rd)
    // Exit to init drops unsaved settings; a saved copy survives reset
    repeat (50) @(posedge pclk);
    cmd(imf_pkg::CMD_SVC);
    apb(1'h1, imf_pkg::OFF_CTRL, 32'h3, rd, e);
    cmd(imf_pkg::CMD_EXIT_INIT);
    @(posedge pclk);
    `CHK("xi_mode", imf_pkg::MODE_INIT, mode)
    apb(1'h0, imf_pkg::OFF_CTRL, 32'h0, rd, e);
    `CHK("xi_ctrl", RST, rd)
    apb(1'h1, imf_pkg::OFF_CTRL, 32'h80, rd, e);
    cmd(imf_pkg::CMD_SAVE);
    ext_reset <= 1'h1;
    @(posedge pclk);
    ext_reset <= 1'h0;
    apb(1'h0, imf_pkg::OFF_CTRL, 32'h0, rd, e);
    `CHK("xr_saved", 32'h80, rd)
    results();
  end
endmodule
